// ==== pmc_bank.sv ====
// Pad and block memory configuration bank, loaded by the configuration flow.
// Assumes the loader writes whole registers by index on clk and then raises
// cfg_load_done; pad levels arrive asynchronously.
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module pmc_bank (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               cfg_wr_en,
  input  wire pmc_pkg::pmc_idx_t  cfg_wr_idx,
  input  wire pmc_pkg::pmc_word_t cfg_wr_data,
  input  wire logic               cfg_load_done,
  input  wire pmc_pkg::pmc_idx_t  cfg_rd_idx,
  output pmc_pkg::pmc_word_t      cfg_rd_data,
  output logic                    cfg_active,
  input  wire logic               power_reset_pad_n,
  input  wire logic               low_power_pad_n,
  output logic [10:0]             pad_pullup2_en,
  output logic [10:0]             pad_pullup1_en,
  output logic [10:0]             pad_open_drain,
  output logic [10:0]             pad_drive_2x,
  output logic                    power_reset_pullup_en,
  output logic                    low_power_pullup_en,
  output logic                    block_memory_grp0_pd,
  output logic                    block_memory_grp1_pd
);
  import pmc_pkg::*;

  typedef struct packed {
    pmc_word_t   pad_a;
    pmc_word_t   pad_b;
    pmc_word_t   mem_pwr;
    logic        active;
    pmc_word_t   rd_data;
    logic [10:0] pu2;
    logic [10:0] pu1;
    logic [10:0] od;
    logic [10:0] d2x;
    logic        rst_pu;
    logic        slp_pu;
    logic        grp0_pd;
    logic        grp1_pd;
  } pmc_bank_state_t;

  pmc_bank_state_t state_ff;
  pmc_bank_state_t nxt_state;
  logic            rst_pad_level;
  logic            slp_pad_level;
  pmc_word_t       eff_pad_a;
  pmc_word_t       eff_pad_b;
  pmc_word_t       eff_mem_pwr;
  logic [43:0]     pad_flat;

  ////////////////////////////////////////////////////////////////////////////
  // Pad level synchronisers for the automatic pull-up mode.
  pmc_sync u_rst_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pad_in    (power_reset_pad_n),
    .pad_level (rst_pad_level)
  );

  pmc_sync u_slp_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pad_in    (low_power_pad_n),
    .pad_level (slp_pad_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pulls one field out of every four-bit pad group.
  function automatic logic [10:0] pad_field(input logic [43:0] flat,
                                            input logic [1:0]  fld);
    logic [10:0] res;
    res = 11'h000;
    for (int p = 0; p < `PMC_PAD_COUNT; p++) begin
      res[p] = flat[4 * p + int'(fld)];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Until loading is complete the pads and memories see the default values,
  // so a half-written bank never reaches the pad ring.
  always_comb begin
    eff_pad_a   = state_ff.active ? state_ff.pad_a   : `PMC_RST_PAD_A;
    eff_pad_b   = state_ff.active ? state_ff.pad_b   : `PMC_RST_PAD_B;
    eff_mem_pwr = state_ff.active ? state_ff.mem_pwr : `PMC_RST_MEM_PWR;
    pad_flat    = {eff_pad_b[`PMC_PAD_B_USED-1:0], eff_pad_a};
  end

  always_comb begin
    nxt_state = state_ff;
    // Writes are accepted only while loading; afterwards the bank is locked
    // until the next reset, as a one-time load would be.
    if (cfg_wr_en && !state_ff.active) begin
      if (cfg_wr_idx == `PMC_IDX_PAD_A) begin
        nxt_state.pad_a = cfg_wr_data;
      end else if (cfg_wr_idx == `PMC_IDX_PAD_B) begin
        nxt_state.pad_b = cfg_wr_data & `PMC_MASK_PAD_B;
      end else if (cfg_wr_idx == `PMC_IDX_MEM_PWR) begin
        nxt_state.mem_pwr = cfg_wr_data & `PMC_MASK_MEM_PWR;
      end
    end
    if (cfg_load_done) begin
      nxt_state.active = 1'b1;
    end
    if (cfg_rd_idx == `PMC_IDX_PAD_A) begin
      nxt_state.rd_data = state_ff.pad_a;
    end else if (cfg_rd_idx == `PMC_IDX_PAD_B) begin
      nxt_state.rd_data = state_ff.pad_b;
    end else if (cfg_rd_idx == `PMC_IDX_MEM_PWR) begin
      nxt_state.rd_data = state_ff.mem_pwr;
    end else begin
      nxt_state.rd_data = 32'h0000_0000;
    end
    nxt_state.pu2     = pad_field(pad_flat, `PMC_FLD_PULLUP2);
    nxt_state.pu1     = pad_field(pad_flat, `PMC_FLD_PULLUP1);
    nxt_state.od      = pad_field(pad_flat, `PMC_FLD_OPEN_DRAIN);
    nxt_state.d2x     = pad_field(pad_flat, `PMC_FLD_DRIVE_2X);
    nxt_state.rst_pu  = eff_pad_b[`PMC_BIT_RST_KEEP_ON] | rst_pad_level;
    nxt_state.slp_pu  = eff_pad_b[`PMC_BIT_SLP_KEEP_ON] | slp_pad_level;
    nxt_state.grp0_pd = eff_mem_pwr[`PMC_BIT_MEM_GRP0_PD];
    nxt_state.grp1_pd = eff_mem_pwr[`PMC_BIT_MEM_GRP1_PD];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '{pad_a:   `PMC_RST_PAD_A,
                    pad_b:   `PMC_RST_PAD_B,
                    mem_pwr: `PMC_RST_MEM_PWR,
                    active:  1'b0,
                    rd_data: 32'h0000_0000,
                    pu2:     11'h000,
                    pu1:     11'h7FF,
                    od:      11'h000,
                    d2x:     11'h000,
                    rst_pu:  1'b1,
                    slp_pu:  1'b1,
                    grp0_pd: 1'b1,
                    grp1_pd: 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cfg_rd_data           = state_ff.rd_data;
  assign cfg_active            = state_ff.active;
  assign pad_pullup2_en        = state_ff.pu2;
  assign pad_pullup1_en        = state_ff.pu1;
  assign pad_open_drain        = state_ff.od;
  assign pad_drive_2x          = state_ff.d2x;
  assign power_reset_pullup_en = state_ff.rst_pu;
  assign low_power_pullup_en   = state_ff.slp_pu;
  assign block_memory_grp0_pd  = state_ff.grp0_pd;
  assign block_memory_grp1_pd  = state_ff.grp1_pd;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_pullup2_map: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pad_pullup2_en[0] == $past(pad_flat[0]))
    else $error("Second pull-up of pad 0 does not follow its bit.");

  chk_pullup1_map: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pad_pullup1_en[10] == $past(pad_flat[41]))
    else $error("First pull-up of pad 10 does not follow its bit.");

  chk_open_drain_map: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pad_open_drain[8] == $past(state_ff.active ? state_ff.pad_b[2] : 1'b0))
    else $error("Driver type of pad 8 does not follow its bit.");

  chk_drive_map: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pad_drive_2x[1] == $past(eff_pad_a[7]))
    else $error("Drive strength of pad 1 does not follow its bit.");

  chk_pad_b_order: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(state_ff.active) |->
      {pad_drive_2x[9], pad_open_drain[9], pad_pullup1_en[9], pad_pullup2_en[9]}
        == $past(state_ff.pad_b[7:4]))
    else $error("Pad group in register 9 bits 4 to 7 is misordered.");

  chk_rst_keep_on: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.active && state_ff.pad_b[16] |=> power_reset_pullup_en)
    else $error("Reset pad pull-up not held on.");

  chk_slp_auto: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.active && !state_ff.pad_b[17] |=> low_power_pullup_en == $past(slp_pad_level))
    else $error("Sleep pad pull-up does not follow the pad.");

  chk_mem_pd: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> {block_memory_grp1_pd, block_memory_grp0_pd} == $past(eff_mem_pwr[1:0]))
    else $error("Block memory power down does not follow its bits.");

  chk_defaults_pre_load: assert property (@(posedge clk) disable iff (sys_rst)
    !state_ff.active |=> pad_pullup1_en == 11'h7FF && pad_pullup2_en == 11'h000
      && block_memory_grp0_pd && block_memory_grp1_pd)
    else $error("Settings took effect before loading completed.");

  ////////////////////////////////////////////////////////////////////////////
  // Every pad is checked field by field, so a slip in the nibble order shows
  // up on the pad where it happens and not only on the pads sampled above.
  for (genvar p = 0; p < `PMC_PAD_COUNT; p++) begin : g_pad_chk
    chk_pad_pullup2: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> pad_pullup2_en[p] == $past(pad_flat[4 * p]))
      else $error("Second pull-up of a pad does not follow its bit.");

    chk_pad_pullup1: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> pad_pullup1_en[p] == $past(pad_flat[4 * p + 1]))
      else $error("First pull-up of a pad does not follow its bit.");

    chk_pad_type: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> pad_open_drain[p] == $past(pad_flat[4 * p + 2]))
      else $error("Driver type of a pad does not follow its bit.");

    chk_pad_strength: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> pad_drive_2x[p] == $past(pad_flat[4 * p + 3]))
      else $error("Drive strength of a pad does not follow its bit.");
  end : g_pad_chk

  ////////////////////////////////////////////////////////////////////////////
  // The edge after reset must show the defaults, whatever an earlier load set.
  chk_reset_pullup2: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pad_pullup2_en == 11'h000)
    else $error("Second pull-ups not cleared by reset.");

  chk_reset_pullup1: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pad_pullup1_en == 11'h7FF)
    else $error("First pull-ups not set by reset.");

  chk_reset_type: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pad_open_drain == 11'h000)
    else $error("Pads not push-pull after reset.");

  chk_reset_strength: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pad_drive_2x == 11'h000)
    else $error("Pads not single strength after reset.");

  chk_reset_mem_pd: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> block_memory_grp0_pd && block_memory_grp1_pd)
    else $error("Block memories not powered down after reset.");

  ////////////////////////////////////////////////////////////////////////////
  // Pad pull-up modes, the load handshake and the lock that follows it.
  chk_rst_auto: assert property (@(posedge clk) disable iff (sys_rst)
    !(state_ff.active && state_ff.pad_b[`PMC_BIT_RST_KEEP_ON]) |=>
      power_reset_pullup_en == $past(rst_pad_level))
    else $error("Reset pad pull-up does not follow the pad.");

  chk_slp_keep_on: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.active && state_ff.pad_b[`PMC_BIT_SLP_KEEP_ON] |=> low_power_pullup_en)
    else $error("Sleep pad pull-up not held on.");

  chk_active_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_active |=> cfg_active)
    else $error("Load completion was lost before reset.");

  chk_load_takes: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_load_done |=> cfg_active)
    else $error("Load completion was not taken.");

  chk_bank_locked: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.active |=> $stable(state_ff.pad_a) && $stable(state_ff.pad_b)
      && $stable(state_ff.mem_pwr))
    else $error("Bank changed after loading completed.");

  chk_write_pad_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_en && !state_ff.active && cfg_wr_idx == `PMC_IDX_PAD_A |=>
      state_ff.pad_a == $past(cfg_wr_data))
    else $error("First pad word was not stored.");

  ////////////////////////////////////////////////////////////////////////////
  // Readback and reserved bits; a reserved bit must never reach the bank.
  chk_read_pad_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_rd_idx == `PMC_IDX_PAD_A |=> cfg_rd_data == $past(state_ff.pad_a))
    else $error("First pad word reads back wrong.");

  chk_read_pad_b: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_rd_idx == `PMC_IDX_PAD_B |=> cfg_rd_data == $past(state_ff.pad_b))
    else $error("Second pad word reads back wrong.");

  chk_read_mem_pwr: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_rd_idx == `PMC_IDX_MEM_PWR |=> cfg_rd_data == $past(state_ff.mem_pwr))
    else $error("Memory power word reads back wrong.");

  chk_read_spare: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_rd_idx != `PMC_IDX_PAD_A && cfg_rd_idx != `PMC_IDX_PAD_B
      && cfg_rd_idx != `PMC_IDX_MEM_PWR |=> cfg_rd_data == 32'h0000_0000)
    else $error("Reserved register did not read as zero.");

  chk_write_pad_b: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_en && !state_ff.active && cfg_wr_idx == `PMC_IDX_PAD_B |=>
      state_ff.pad_b == ($past(cfg_wr_data) & `PMC_MASK_PAD_B))
    else $error("Reserved bits of the second pad word were kept.");

  chk_write_mem_pwr: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr_en && !state_ff.active && cfg_wr_idx == `PMC_IDX_MEM_PWR |=>
      state_ff.mem_pwr == ($past(cfg_wr_data) & `PMC_MASK_MEM_PWR))
    else $error("Reserved bits of the memory power word were kept.");

  chk_pad_b_spare: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.pad_b[15:12] == 4'h0 && state_ff.pad_b[31:18] == 14'h0)
    else $error("Reserved bits of the second pad word are set.");

  chk_mem_spare: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff.mem_pwr[31:2] == 30'h0)
    else $error("Reserved bits of the memory power word are set.");

endmodule // pmc_bank

// ==== pmc_cfg.svh ====
// Constants of the pad and block memory configuration bank.
// Assumes one 125 MHz clock and a configuration source that writes whole registers.
// Summary of operation
// - Second pull-up bit one enables that pad's second pull-up; default zero.
// - First pull-up bit one enables that pad's first pull-up; default one.
// - Driver type bit zero gives push-pull, one gives open-drain; default push-pull.
// - Strength bit zero gives single drive, one gives double drive; default single.
// - Each pad owns four bits: second pull-up, first pull-up, type, strength.
// - Register 9 bit 16 keeps the reset pad pull-up on, else follows input.
// - Register 9 bit 17 keeps the sleep pad pull-up on, else follows input.
// - Register 10 bits 0 and 1 power down memory groups 0-3 and 4-7.
// - Settings take effect only after the whole bank has been loaded.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_IDX_PAD_A        4'h8
`define PMC_IDX_PAD_B        4'h9
`define PMC_IDX_MEM_PWR      4'hA
`define PMC_IDX_SPARE_LO     4'hB
`define PMC_IDX_SPARE_HI     4'hE

`define PMC_PAD_COUNT        11
`define PMC_PAD_B_USED       12
`define PMC_FLD_PULLUP2      2'h0
`define PMC_FLD_PULLUP1      2'h1
`define PMC_FLD_OPEN_DRAIN   2'h2
`define PMC_FLD_DRIVE_2X     2'h3
`define PMC_BIT_RST_KEEP_ON  16
`define PMC_BIT_SLP_KEEP_ON  17
`define PMC_BIT_MEM_GRP0_PD  0
`define PMC_BIT_MEM_GRP1_PD  1

`define PMC_RST_PAD_A        32'h2222_2222
`define PMC_RST_PAD_B        32'h0000_0222
`define PMC_RST_MEM_PWR      32'h0000_0003
`define PMC_MASK_PAD_B       32'h0003_0FFF
`define PMC_MASK_MEM_PWR     32'h0000_0003

`endif

// ==== pmc_pkg.sv ====
// Types shared by the configuration bank modules.
// Assumes pmc_cfg.svh is compiled alongside.
package pmc_pkg;

  typedef logic [3:0]  pmc_idx_t;
  typedef logic [31:0] pmc_word_t;

endpackage

// ==== pmc_sync.sv ====
// Three-stage pad input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns

module pmc_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pad_in,
  output logic      pad_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } pmc_sync_state_t;

  pmc_sync_state_t state_ff;
  pmc_sync_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second; a change counts once stages two
  // and three agree, which hides a single metastable sample.
  always_comb begin
    nxt_state    = state_ff;
    nxt_state.s1 = pad_in;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    if (state_ff.s2 == state_ff.s3) begin
      nxt_state.level = state_ff.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pad_level = state_ff.level;

endmodule // pmc_sync

// ==== pad_and_memory_config_bits_tb.sv ====
// Self-checking bench for the pad and block memory configuration bank.
// Assumes pmc_pkg and pmc_bank are compiled first; inputs change on falling edges.
`timescale 1ns/1ns

module pad_and_memory_config_bits_tb;
  import pmc_pkg::*;

  logic        clk, sys_rst, cfg_wr_en, cfg_load_done, cfg_active;
  pmc_idx_t    cfg_wr_idx, cfg_rd_idx;
  pmc_word_t   cfg_wr_data, cfg_rd_data;
  logic        power_reset_pad_n, low_power_pad_n;
  logic [10:0] pad_pullup2_en, pad_pullup1_en, pad_open_drain, pad_drive_2x;
  logic        power_reset_pullup_en, low_power_pullup_en;
  logic        block_memory_grp0_pd, block_memory_grp1_pd;
  int          mismatches, cmp_count;

  // Loaded words; the bank must drop reserved bits of the second pad word and power word.
  localparam pmc_word_t WA = 32'h9C36_A5F1;
  localparam pmc_word_t WB = 32'hFFFE_F5A9;
  localparam pmc_word_t WM = 32'hFFFF_FFFE;
  // Second load keeps every reserved bit zero, as a well-behaved source does.
  localparam pmc_word_t WA2 = 32'h6DB4_18E0;
  localparam pmc_word_t WB2 = 32'h0001_0C34;

  pmc_bank u_dut (
    .clk(clk), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en), .cfg_wr_idx(cfg_wr_idx),
    .cfg_wr_data(cfg_wr_data), .cfg_load_done(cfg_load_done), .cfg_rd_idx(cfg_rd_idx),
    .cfg_rd_data(cfg_rd_data), .cfg_active(cfg_active),
    .power_reset_pad_n(power_reset_pad_n), .low_power_pad_n(low_power_pad_n),
    .pad_pullup2_en(pad_pullup2_en), .pad_pullup1_en(pad_pullup1_en),
    .pad_open_drain(pad_open_drain), .pad_drive_2x(pad_drive_2x),
    .power_reset_pullup_en(power_reset_pullup_en), .low_power_pullup_en(low_power_pullup_en),
    .block_memory_grp0_pd(block_memory_grp0_pd), .block_memory_grp1_pd(block_memory_grp1_pd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input pmc_idx_t idx, input pmc_word_t data);
    cfg_wr_idx = idx;
    cfg_wr_data = data;
    cfg_wr_en = 1'b1;
    @(negedge clk);
    cfg_wr_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input pmc_idx_t idx, input pmc_word_t exp);
    cfg_rd_idx = idx;
    @(negedge clk);
    check({32'h0, cfg_rd_data}, {32'h0, exp}, "readback");
  endtask

  // Flat nibble p holds pull-up two, pull-up one, open drain, double drive from bit 0 up.
  function automatic logic [63:0] exp_pads(input logic [43:0] flat);
    logic [10:0] p2, p1, od, dr;
    for (int p = 0; p < 11; p++) begin
      p2[p] = flat[4*p];
      p1[p] = flat[4*p+1];
      od[p] = flat[4*p+2];
      dr[p] = flat[4*p+3];
    end
    return {20'h0, p2, p1, od, dr};
  endfunction

  task automatic check_pads(input logic [43:0] flat, input logic [3:0] misc);
    check({20'h0, pad_pullup2_en, pad_pullup1_en, pad_open_drain, pad_drive_2x},
          exp_pads(flat), "pad fields");
    check({60'h0, power_reset_pullup_en, low_power_pullup_en, block_memory_grp0_pd,
           block_memory_grp1_pd}, {60'h0, misc}, "pull-up and power");
  endtask

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check_pads(44'h222_2222_2222, 4'hF);
    check({63'h0, cfg_active}, 64'h0, "inactive after reset");
  endtask

  // Ends loading and waits, with a bound, until the bank reports itself active.
  task automatic wait_active();
    cfg_load_done = 1'b1;
    for (int i = 0; i <= 10; i++) begin
      if (i == 10) begin
        check(64'h0, 64'h1, "load never completed");
        finish_test();
      end
      @(negedge clk);
      if (cfg_active === 1'b1) break;
    end
    cfg_load_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {cfg_wr_en, cfg_load_done, cfg_wr_idx, cfg_rd_idx, cfg_wr_data} = '0;
    {power_reset_pad_n, low_power_pad_n} = 2'b11;
    mismatches = 0;
    cmp_count = 0;
    do_reset();
    rd(4'h8, 32'h2222_2222);
    rd(4'h9, 32'h0000_0222);
    rd(4'hA, 32'h0000_0003);
    $display("test defaults done");
    wr(4'h8, WA);
    wr(4'h9, WB);
    wr(4'hA, WM);
    for (int i = 11; i < 16; i++) wr(4'(i), 32'hFFFF_FFFF);
    wr(4'h0, 32'hFFFF_FFFF);
    check_pads(44'h222_2222_2222, 4'hF);
    rd(4'h8, WA);
    rd(4'h9, WB & 32'h0003_0FFF);
    rd(4'hA, WM & 32'h0000_0003);
    for (int i = 11; i < 16; i++) rd(4'(i), 32'h0);
    rd(4'h0, 32'h0);
    wait_active();
    check_pads({WB[11:0], WA}, 4'b1101);
    $display("test load done");
    // Reset pad follows its input; sleep pad is held on by its keep bit.
    power_reset_pad_n = 1'b0;
    low_power_pad_n = 1'b0;
    repeat (8) @(negedge clk);
    check_pads({WB[11:0], WA}, 4'b0101);
    power_reset_pad_n = 1'b1;
    repeat (8) @(negedge clk);
    check_pads({WB[11:0], WA}, 4'b1101);
    $display("test pad pull-ups done");
    // Once loaded the bank is locked until the next reset.
    wr(4'h8, 32'h0);
    rd(4'h8, WA);
    check_pads({WB[11:0], WA}, 4'b1101);
    $display("test lock done");
    low_power_pad_n = 1'b1;
    do_reset();
    rd(4'h8, 32'h2222_2222);
    $display("test second reset done");
    // Reset pad pull-up held on by its keep bit; sleep pad pull-up follows its input.
    wr(4'h8, WA2);
    wr(4'h9, WB2);
    wr(4'hA, 32'h0000_0000);
    wait_active();
    check_pads({WB2[11:0], WA2}, 4'b1100);
    power_reset_pad_n = 1'b0;
    low_power_pad_n = 1'b0;
    repeat (8) @(negedge clk);
    check_pads({WB2[11:0], WA2}, 4'b1000);
    low_power_pad_n = 1'b1;
    repeat (8) @(negedge clk);
    check_pads({WB2[11:0], WA2}, 4'b1100);
    rd(4'h9, WB2);
    $display("test keep on and automatic done");
    finish_test();
  end
endmodule // pad_and_memory_config_bits_tb
